/* File: pkg/tdsc_map.svh */
// Register indices, field positions, masks and reset values of the stop configuration
`ifndef TDSC_MAP_SVH
`define TDSC_MAP_SVH

// Word indices on the configuration load port
`define TDSC_IDX_ITER_LIMIT 4'h2
`define TDSC_IDX_DECODE_OPTION 4'h3
`define TDSC_IDX_CRC_STOP 4'h4
`define TDSC_IDX_CRC_POLY 4'h5

// Writable bit masks; everything else is reserved
`define TDSC_MASK_ITER_LIMIT 32'h001f_0000
`define TDSC_MASK_DECODE_OPTION 32'h0000_51f3
`define TDSC_MASK_CRC_STOP 32'h0000_1f3f
`define TDSC_MASK_CRC_POLY 32'hffff_ffff
`define TDSC_RESET_VALUE 32'h0000_0000

// Field positions
`define TDSC_MAX_ITER_LSB 16
`define TDSC_OUT_ORDER_BIT 14
`define TDSC_INPUT_NEGATE_BIT 12
`define TDSC_MIN_ITER_LSB 4
`define TDSC_PROLOG_REDUCE_BIT 1
`define TDSC_LOG_MAP_BIT 0
`define TDSC_CRC_PASS_LSB 8
`define TDSC_CRC_LEN_LSB 0

// Counts
`define TDSC_ITER_ZERO_AS 6'h20
`define TDSC_WORD_BITS 32

`endif

/* File: pkg/tdsc_pkg.sv */
// Types shared by the stop configuration block
package tdsc_pkg;
  typedef logic [4:0] tdsc_iter_t;
  typedef logic [5:0] tdsc_count_t;
  typedef logic [31:0] tdsc_word_t;
  typedef enum logic {TDSC_PACK_LSB_FIRST, TDSC_PACK_MSB_FIRST} tdsc_pack_e;
  typedef enum logic [1:0] {TDSC_IDLE, TDSC_RUN, TDSC_DONE} tdsc_state_e;
endpackage

/* File: rtl/tdsc_stop_ctrl.sv */
// Iteration counter and early stop decision of the decoder
`timescale 1ns/100ps
`include "tdsc_map.svh"
module tdsc_stop_ctrl (
  input wire logic clock,
  input wire logic reset,
  input wire logic decode_start,
  input wire logic iter_end,
  input wire logic crc_pass,
  input wire tdsc_pkg::tdsc_iter_t min_iterations,
  input wire tdsc_pkg::tdsc_iter_t max_iterations,
  input wire tdsc_pkg::tdsc_iter_t crc_pass_count,
  input wire logic [5:0] crc_length,
  output tdsc_pkg::tdsc_count_t iter_count,
  output logic decode_stop,
  output logic decode_busy
);
  tdsc_pkg::tdsc_state_e state_reg;
  tdsc_pkg::tdsc_count_t pass_run_reg;
  tdsc_pkg::tdsc_count_t iter_next;
  tdsc_pkg::tdsc_count_t pass_run_next;
  tdsc_pkg::tdsc_count_t min_eff;
  tdsc_pkg::tdsc_count_t max_eff;
  tdsc_pkg::tdsc_count_t pass_eff;
  logic crc_enable;
  logic stop_now;

  // Zero means one for both floors
  function automatic tdsc_pkg::tdsc_count_t zero_as_one(input tdsc_pkg::tdsc_iter_t v);
    zero_as_one = (v == 5'h00) ? 6'h01 : {1'b0, v};
  endfunction

  // Effective limits and the stop decision for the iteration just ending
  always_comb begin
    min_eff = zero_as_one(min_iterations);
    max_eff = (max_iterations == 5'h00) ? `TDSC_ITER_ZERO_AS : {1'b0, max_iterations};
    pass_eff = zero_as_one(crc_pass_count);
    crc_enable = (crc_length != 6'h00);
    iter_next = iter_count + 6'h01;
    pass_run_next = (crc_enable && crc_pass) ? pass_run_reg + 6'h01 : 6'h00;
    // CRC stop is held off until the floor is met; the ceiling always wins
    stop_now = (iter_next >= max_eff) ||
               (crc_enable && iter_next >= min_eff && pass_run_next >= pass_eff);
  end

  // Sequencing of one decode
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= tdsc_pkg::TDSC_IDLE;
      iter_count <= 6'h00;
      pass_run_reg <= 6'h00;
      decode_stop <= 1'b0;
      decode_busy <= 1'b0;
    end else begin
      decode_stop <= 1'b0;
      case (state_reg)
        tdsc_pkg::TDSC_IDLE, tdsc_pkg::TDSC_DONE: begin
          if (decode_start) begin
            state_reg <= tdsc_pkg::TDSC_RUN;
            iter_count <= 6'h00;
            pass_run_reg <= 6'h00;
            decode_busy <= 1'b1;
          end
        end
        tdsc_pkg::TDSC_RUN: begin
          if (iter_end) begin
            iter_count <= iter_next;
            // Saturates at 31; the 32 ceiling stops first anyway
            pass_run_reg <= (pass_run_next > 6'h1f) ? 6'h1f : pass_run_next;
            if (stop_now) begin
              state_reg <= tdsc_pkg::TDSC_DONE;
              decode_stop <= 1'b1;
              decode_busy <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= tdsc_pkg::TDSC_IDLE;
          decode_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* File: rtl/tdsc_top.sv */
// Turbo decoder stop configuration registers with CRC check and output packing
// Notes on behaviour
// - Option bit 14 packs hard decisions from bit 0 upward when 0 and from bit 31 down when 1.
// - Option bit 12 set negates every incoming soft value except the most negative, which saturates to the largest positive; clear passes it unchanged.
// - At least the minimum iteration count in bits 8-4 runs before an early stop, 0 meaning 1.
// - Option bit 0 picks log-MAP when 1 and max-log-MAP when 0, bit 1 enables prolog reduction.
// - Reserved bits read as 0 and writes to them change nothing.
// - Decoding stops on CRC only after the pass count in bits 12-8 of consecutive passes, 0 meaning 1.
// - The CRC length in bits 5-0 ranges 0-32 and 0 disables CRC checking and CRC stopping.
// - The CRC generator word is stored in full; the checker takes bits 30-0 shifted up one place above an implied 1, cut to the CRC length.
// - The maximum count sits in bits 20-16 of the limit word, 0 meaning 32 iterations.
`timescale 1ns/100ps
`include "tdsc_map.svh"
module tdsc_top #(
  parameter int SOFT_WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [3:0] cfg_index,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic soft_valid,
  input wire logic signed [SOFT_WIDTH-1:0] soft_in,
  output logic soft_out_valid,
  output logic signed [SOFT_WIDTH-1:0] soft_out,
  output logic log_map_select,
  output logic prolog_reduce_en,
  input wire logic decode_start,
  input wire logic hard_valid,
  input wire logic hard_bit,
  input wire logic hard_last,
  output logic [31:0] hard_word,
  output logic hard_word_valid,
  output logic crc_done,
  output logic crc_ok,
  output logic decode_stop,
  output logic decode_busy,
  output logic [5:0] iter_count
);
  tdsc_pkg::tdsc_word_t iter_limit_reg;
  tdsc_pkg::tdsc_word_t decode_option_reg;
  tdsc_pkg::tdsc_word_t crc_stop_reg;
  tdsc_pkg::tdsc_word_t crc_poly_reg;
  tdsc_pkg::tdsc_word_t crc_state_reg;
  tdsc_pkg::tdsc_word_t crc_state_next;
  tdsc_pkg::tdsc_word_t pack_reg;
  tdsc_pkg::tdsc_word_t pack_next;
  logic [4:0] pack_count_reg;
  logic [4:0] pack_pos;
  tdsc_pkg::tdsc_pack_e output_bit_order;
  logic input_negate;
  tdsc_pkg::tdsc_iter_t min_iterations;
  tdsc_pkg::tdsc_iter_t max_iterations;
  tdsc_pkg::tdsc_iter_t crc_pass_count;
  logic [5:0] crc_length;
  logic crc_pass_pulse;
  logic iter_end;

  // Mask of the low len bits, len 0..32
  function automatic tdsc_pkg::tdsc_word_t len_mask(input logic [5:0] len);
    len_mask = (len >= 6'h20) ? 32'hffff_ffff : ((32'h0000_0001 << len) - 32'h0000_0001);
  endfunction

  // One serial CRC step; taps are 1 + poly bits shifted up one place
  function automatic tdsc_pkg::tdsc_word_t crc_step(input tdsc_pkg::tdsc_word_t state,
                                                    input logic din,
                                                    input tdsc_pkg::tdsc_word_t poly,
                                                    input logic [5:0] len);
    tdsc_pkg::tdsc_word_t taps;
    logic fb;
    taps = {poly[30:0], 1'b1} & len_mask(len);
    fb = din ^ state[len[4:0] - 5'h01];
    crc_step = ({state[30:0], 1'b0} ^ (fb ? taps : 32'h0000_0000)) & len_mask(len);
  endfunction

  // Field views of the stored words
  assign output_bit_order = tdsc_pkg::tdsc_pack_e'(decode_option_reg[`TDSC_OUT_ORDER_BIT]);
  assign input_negate = decode_option_reg[`TDSC_INPUT_NEGATE_BIT];
  assign min_iterations = decode_option_reg[`TDSC_MIN_ITER_LSB +: 5];
  assign max_iterations = iter_limit_reg[`TDSC_MAX_ITER_LSB +: 5];
  assign crc_pass_count = crc_stop_reg[`TDSC_CRC_PASS_LSB +: 5];
  assign crc_length = crc_stop_reg[`TDSC_CRC_LEN_LSB +: 6];
  assign iter_end = hard_valid && hard_last;

  // Configuration words; reserved bits never stored so they read back 0
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      iter_limit_reg <= `TDSC_RESET_VALUE;
      decode_option_reg <= `TDSC_RESET_VALUE;
      crc_stop_reg <= `TDSC_RESET_VALUE;
      crc_poly_reg <= `TDSC_RESET_VALUE;
    end else if (cfg_write) begin
      case (cfg_index)
        `TDSC_IDX_ITER_LIMIT: iter_limit_reg <= cfg_wdata & `TDSC_MASK_ITER_LIMIT;
        `TDSC_IDX_DECODE_OPTION: begin
          decode_option_reg <= cfg_wdata & `TDSC_MASK_DECODE_OPTION;
        end
        `TDSC_IDX_CRC_STOP: crc_stop_reg <= cfg_wdata & `TDSC_MASK_CRC_STOP;
        `TDSC_IDX_CRC_POLY: crc_poly_reg <= cfg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read answers one cycle later; unmapped indices read 0
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_read;
      case (cfg_index)
        `TDSC_IDX_ITER_LIMIT: cfg_rdata <= iter_limit_reg;
        `TDSC_IDX_DECODE_OPTION: cfg_rdata <= decode_option_reg;
        `TDSC_IDX_CRC_STOP: cfg_rdata <= crc_stop_reg;
        `TDSC_IDX_CRC_POLY: cfg_rdata <= crc_poly_reg;
        default: cfg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Metric options copied to flops for the datapath
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      log_map_select <= 1'b0;
      prolog_reduce_en <= 1'b0;
    end else begin
      log_map_select <= decode_option_reg[`TDSC_LOG_MAP_BIT];
      prolog_reduce_en <= decode_option_reg[`TDSC_PROLOG_REDUCE_BIT];
    end
  end

  // Soft value sign stage; most negative value saturates rather than wrapping
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      soft_out <= '0;
      soft_out_valid <= 1'b0;
    end else begin
      soft_out_valid <= soft_valid;
      if (!input_negate) begin
        soft_out <= soft_in;
      end else if (soft_in == {1'b1, {(SOFT_WIDTH-1){1'b0}}}) begin
        soft_out <= {1'b0, {(SOFT_WIDTH-1){1'b1}}};
      end else begin
        soft_out <= -soft_in;
      end
    end
  end

  // Bit position inside the word for the chosen packing order
  always_comb begin
    if (output_bit_order == tdsc_pkg::TDSC_PACK_MSB_FIRST) begin
      pack_pos = 5'h1f - pack_count_reg;
    end else begin
      pack_pos = pack_count_reg;
    end
    pack_next = pack_reg;
    pack_next[pack_pos] = hard_bit;
  end

  // Word packer; a short last word leaves its unfilled bits at 0
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pack_reg <= 32'h0000_0000;
      pack_count_reg <= 5'h00;
      hard_word <= 32'h0000_0000;
      hard_word_valid <= 1'b0;
    end else begin
      hard_word_valid <= 1'b0;
      if (hard_valid) begin
        if (hard_last || pack_count_reg == 5'h1f) begin
          hard_word <= pack_next;
          hard_word_valid <= 1'b1;
          pack_reg <= 32'h0000_0000;
          pack_count_reg <= 5'h00;
        end else begin
          pack_reg <= pack_next;
          pack_count_reg <= pack_count_reg + 5'h01;
        end
      end
    end
  end

  // CRC over each iteration's decisions, appended parity included
  always_comb begin
    crc_state_next = crc_step(crc_state_reg, hard_bit, crc_poly_reg, crc_length);
  end

  // A zero remainder at the last bit means the block passed
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      crc_state_reg <= 32'h0000_0000;
      crc_done <= 1'b0;
      crc_ok <= 1'b0;
    end else begin
      crc_done <= 1'b0;
      if (decode_start) begin
        crc_state_reg <= 32'h0000_0000;
      end else if (hard_valid && crc_length != 6'h00) begin
        crc_state_reg <= hard_last ? 32'h0000_0000 : crc_state_next;
        if (hard_last) begin
          crc_done <= 1'b1;
          crc_ok <= (crc_state_next == 32'h0000_0000);
        end
      end
    end
  end

  // Pass result seen by the stop logic in the same cycle as the last bit
  assign crc_pass_pulse = (crc_length != 6'h00) && (crc_state_next == 32'h0000_0000);

  tdsc_stop_ctrl u_stop (
    .clock(clock),
    .reset(reset),
    .decode_start(decode_start),
    .iter_end(iter_end),
    .crc_pass(crc_pass_pulse),
    .min_iterations(min_iterations),
    .max_iterations(max_iterations),
    .crc_pass_count(crc_pass_count),
    .crc_length(crc_length),
    .iter_count(iter_count),
    .decode_stop(decode_stop),
    .decode_busy(decode_busy)
  );
endmodule

/* File: testbench/tdsc_checker_assertions.sv */
// Port checker of the stop configuration block
`timescale 1ns/100ps
module tdsc_checker #(
  parameter int SOFT_WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [3:0] cfg_index,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic soft_valid,
  input wire logic signed [SOFT_WIDTH-1:0] soft_in,
  input wire logic signed [SOFT_WIDTH-1:0] soft_out,
  input wire logic soft_out_valid,
  input wire logic log_map_select,
  input wire logic prolog_reduce_en,
  input wire logic hard_valid,
  input wire logic hard_last,
  input wire logic hard_word_valid,
  input wire logic crc_done,
  input wire logic decode_stop,
  input wire logic [5:0] iter_count
);
  logic [31:0] sh [6];
  logic [5:0] max_eff;
  logic [5:0] min_eff;
  // Shadow of the loaded words, so outputs can be tied to what was written
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sh <= '{default: 32'h0};
    end else if (cfg_write && cfg_index < 4'h6) begin
      sh[cfg_index[2:0]] <= cfg_wdata;
    end
  end
  // Zero in a count field stands for its special value
  assign max_eff = (sh[2][20:16] == 5'h0) ? 6'h20 : {1'b0, sh[2][20:16]};
  assign min_eff = (sh[3][8:4] == 5'h0) ? 6'h01 : {1'b0, sh[3][8:4]};
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_read_answer: assert property (cfg_read |=> cfg_rvalid) else $error("no answer");
  chk_option_masked: assert property (cfg_read && cfg_index == 4'h3
    |=> (cfg_rdata & ~32'h0000_51f3) == 32'h0) else $error("reserved bit");
  chk_mode_copy: assert property (!cfg_write [*2] |->
    log_map_select == sh[3][0] && prolog_reduce_en == sh[3][1]) else $error("mode bits");
  chk_soft_sign: assert property (soft_valid && !cfg_write && soft_in != -soft_in |=>
    soft_out_valid && soft_out == ($past(sh[3][12]) ? -$past(soft_in) : $past(soft_in)))
    else $error("soft value");
  chk_word_out: assert property (hard_valid && hard_last |=> hard_word_valid)
    else $error("no word");
  chk_crc_gate: assert property (hard_valid && hard_last
    |=> crc_done == ($past(sh[4][5:0]) != 6'h0)) else $error("crc gating");
  chk_stop_limit: assert property (decode_stop && sh[4][5:0] == 6'h0
    |-> iter_count == max_eff) else $error("stop not at limit");
  chk_stop_min: assert property (decode_stop && iter_count != max_eff
    |-> iter_count >= min_eff) else $error("stop before minimum");
endmodule
bind tdsc_top tdsc_checker #(.SOFT_WIDTH(SOFT_WIDTH)) u_tdsc_checker (.*);

/* File: testbench/tdsc_dma_model.sv */
// Loader model that writes and reads configuration words
`timescale 1ns/100ps
module tdsc_dma_model (
  input wire logic clock,
  output logic cfg_write,
  output logic cfg_read,
  output logic [3:0] cfg_index,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  // Idle bus at time zero
  initial begin
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_index = 4'h0;
    cfg_wdata = 32'h0;
  end
  // Released data is inverted so a stale word cannot pass
  task automatic wr(input logic [3:0] idx, input logic [31:0] data);
    @(posedge clock);
    cfg_index <= idx;
    cfg_wdata <= data;
    cfg_write <= 1'b1;
    @(posedge clock);
    cfg_write <= 1'b0;
    cfg_wdata <= ~data;
  endtask
  // Index held until the answer; data taken at the edge where the valid pulse is seen high
  task automatic rd(input logic [3:0] idx, output logic [31:0] data);
    @(posedge clock);
    cfg_index <= idx;
    cfg_read <= 1'b1;
    @(posedge clock);
    cfg_read <= 1'b0;
    // Read before this edge's updates land; the valid pulse drops right after it
    @(posedge clock);
    data = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
  endtask
endmodule

/* File: testbench/tdsc_top_test.sv */
// Self-checking bench of the stop configuration block
`timescale 1ns/100ps
`include "tdsc_map.svh"
module tdsc_top_test;
  logic clock, cfg_write, cfg_read, cfg_rvalid, soft_out_valid, hard_word_valid, crc_done;
  logic log_map_select, prolog_reduce_en, crc_ok, decode_stop, decode_busy;
  logic reset = 1'b1, soft_valid = 1'b0, decode_start = 1'b0;
  logic hard_valid = 1'b0, hard_bit = 1'b0, hard_last = 1'b0;
  logic signed [7:0] soft_in = 8'sh05, soft_out;
  logic [3:0] cfg_index;
  logic [31:0] cfg_wdata, cfg_rdata, hard_word, rd;
  logic [31:0] masks [7] = '{32'h0, 32'h0, `TDSC_MASK_ITER_LIMIT, `TDSC_MASK_DECODE_OPTION,
    `TDSC_MASK_CRC_STOP, `TDSC_MASK_CRC_POLY, 32'h0};
  logic [4:0] pat = 5'b11011;
  logic [5:0] iter_count;
  int failures = 0, n_tests = 0;
  tdsc_top u_tdsc_top (.*);
  tdsc_dma_model u_tdsc_dma_model (.*);
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bit k of w goes out k-th; outputs read at the next edge, while one-cycle pulses stand
  task automatic send(input logic [31:0] w, input int n, input logic last);
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      hard_valid <= 1'b1;
      hard_bit <= w[k];
      hard_last <= last && k == n - 1;
    end
    @(posedge clock);
    hard_valid <= 1'b0;
    hard_last <= 1'b0;
    @(posedge clock);
  endtask
  task automatic start;
    @(posedge clock);
    decode_start <= 1'b1;
    @(posedge clock);
    decode_start <= 1'b0;
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    for (int i = 2; i < 7; i++) begin
      u_tdsc_dma_model.rd(i[3:0], rd);
      check(rd, 32'h0);
      u_tdsc_dma_model.wr(i[3:0], 32'hffff_ffff);
      u_tdsc_dma_model.rd(i[3:0], rd);
      check(rd, masks[i]);
    end
    check({log_map_select, prolog_reduce_en}, 2'b11);
    $display("register test done");
    // Option word now has negation on
    @(posedge clock);
    soft_valid <= 1'b1;
    @(posedge clock);
    soft_valid <= 1'b0;
    // Valid pulse stands only until this edge, so it is read before the edge's updates
    @(posedge clock);
    check({soft_out_valid, 23'h0, soft_out}, {1'b1, 23'h0, 8'hfb});
    $display("soft test done");
    // Full word, then a short closing word, in both packing orders
    for (int n = 0; n < 2; n++) begin
      u_tdsc_dma_model.wr(`TDSC_IDX_DECODE_OPTION, n ? 32'h0000_4000 : 32'h0);
      send(32'h8000_00c5, 32, 1'b0);
      check(hard_word, n ? 32'ha300_0001 : 32'h8000_00c5);
      send(32'h5, 3, 1'b1);
      check(hard_word, n ? 32'ha000_0000 : 32'h5);
    end
    $display("packing test done");
    u_tdsc_dma_model.wr(`TDSC_IDX_ITER_LIMIT, 32'h0002_0000);
    u_tdsc_dma_model.wr(`TDSC_IDX_CRC_STOP, 32'h0);
    start();
    for (int n = 1; n < 3; n++) begin
      send(32'h0, 7, 1'b1);
      check({decode_busy, decode_stop, iter_count}, {n != 2, n == 2, n[5:0]});
    end
    $display("limit test done");
    // Pass, pass, fail, pass, pass: minimum four and two in a row end at five
    u_tdsc_dma_model.wr(`TDSC_IDX_ITER_LIMIT, 32'h0);
    u_tdsc_dma_model.wr(`TDSC_IDX_CRC_POLY, 32'h0000_0023);
    u_tdsc_dma_model.wr(`TDSC_IDX_CRC_STOP, 32'h0000_0206);
    u_tdsc_dma_model.wr(`TDSC_IDX_DECODE_OPTION, 32'h0000_0040);
    start();
    for (int n = 0; n < 5; n++) begin
      send(pat[n] ? 32'h71 : 32'h31, 7, 1'b1);
      check({decode_busy, decode_stop, crc_ok, iter_count},
            {n != 4, n == 4, pat[n], n[5:0] + 6'h1});
    end
    $display("crc stop test done");
    finish_test();
  end
endmodule
